/* rtl/remote_output_status_map.sv */
// Remote output status map: sixteen assignable status slots in a read-only register pair.
// Assumes commands and speed/torque figures come from logic on mclk, and driver
// condition levels arrive from pins outside the clock domain.
`timescale 1ns/1ps
module remote_output_status_map
    import remote_out_pkg::*;
#(
    parameter int SPEED_W  = 16,
    parameter int TORQUE_W = 16
)(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                rd_en,
    input  wire logic [ADDR_W-1:0]   rd_addr,
    output logic                     rd_valid,
    output logic                     rd_err,
    output logic      [DATA_W-1:0]   rd_data,
    input  wire logic                wr_en,
    input  wire logic [ADDR_W-1:0]   wr_addr,
    output logic                     wr_ack,
    output logic                     wr_err,
    input  wire logic                cfg_wr,
    input  wire logic [3:0]          cfg_slot,
    input  wire src_e                cfg_src,
    input  wire logic                three_wire,
    input  wire cmd_s                cmd,
    input  wire pin_cond_s           cond_pins,
    input  wire logic [SPEED_W-1:0]  set_speed,
    input  wire logic [SPEED_W-1:0]  actual_speed,
    input  wire logic [SPEED_W-1:0]  speed_band,
    input  wire logic [TORQUE_W-1:0] load_torque,
    input  wire logic [TORQUE_W-1:0] torque_limit_val,
    input  wire logic [TORQUE_W-1:0] overload_level,
    output logic      [DATA_W-1:0]   status_word
);

    logic [PIN_COND_W-1:0] pins_q;
    pin_cond_s             pins_sync;
    cond_s                 cond;
    logic [SPEED_W-1:0]    speed_diff;

    map_t                  map_r;
    map_t                  map_nxt;
    logic [DATA_W-1:0]     status_r;
    logic [DATA_W-1:0]     status_nxt;

    logic                  rd_valid_r;
    logic                  rd_valid_nxt;
    logic                  rd_err_r;
    logic                  rd_err_nxt;
    logic [DATA_W-1:0]     rd_data_r;
    logic [DATA_W-1:0]     rd_data_nxt;
    logic                  wr_ack_r;
    logic                  wr_ack_nxt;
    logic                  wr_err_r;
    logic                  wr_err_nxt;

    function automatic logic exceeds(input logic [TORQUE_W-1:0] val,
                                     input logic [TORQUE_W-1:0] lim);
        exceeds = val > lim;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == OFS_STATUS_UPPER) || (addr == OFS_STATUS_LOWER);
    endfunction

    // Level of one source; three-wire mode swaps the echo set under the same codes
    function automatic logic src_value(input src_e code,
                                       input logic tw,
                                       input cmd_s c,
                                       input cond_s k);
        case (code)
            SRC_FWD_ECHO:      src_value = tw ? c.run_gate : c.fwd;
            SRC_REV_ECHO:      src_value = tw ? c.brake_gate : c.rev;
            SRC_STOP_SEL_ECHO: src_value = tw ? c.dir_sel : c.stop_sel;
            SRC_RUN_GATE_ECHO: src_value = c.run_gate;
            SRC_BRAKE_ECHO:    src_value = c.brake_gate;
            SRC_DIR_SEL_ECHO:  src_value = c.dir_sel;
            SRC_BRAKE_REL:     src_value = c.brake_release;
            SRC_SHAFT_FREE:    src_value = c.shaft_free;
            SRC_DATA_SEL0:     src_value = c.data_sel[0];
            SRC_DATA_SEL1:     src_value = c.data_sel[1];
            SRC_DATA_SEL2:     src_value = c.data_sel[2];
            SRC_FAULT:         src_value = k.pins.fault;
            SRC_WARNING:       src_value = k.pins.warning;
            SRC_MOTION:        src_value = k.pins.motion;
            SRC_TORQUE_LIMIT:  src_value = k.torque_limit;
            SRC_SPEED_BAND:    src_value = k.speed_band;
            SRC_BUSY:          src_value = k.pins.internal_busy;
            SRC_OVERLOAD:      src_value = k.overload;
            SRC_MAIN_POWER:    src_value = k.pins.main_power;
            SRC_SHAFT_DIR:     src_value = k.pins.shaft_fwd;
            default:           src_value = 1'b0;
        endcase
    endfunction

    slot_sync #(
        .WIDTH (PIN_COND_W)
    ) u_pin_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    (cond_pins),
        .q    (pins_q)
    );

    assign pins_sync = pin_cond_s'(pins_q);

    // Derived conditions from the numeric figures
    always_comb
    begin
        speed_diff        = (set_speed >= actual_speed) ? set_speed - actual_speed
                                                        : actual_speed - set_speed;
        cond.pins         = pins_sync;
        cond.torque_limit = exceeds(load_torque, torque_limit_val);
        cond.speed_band   = speed_diff > speed_band;
        cond.overload     = exceeds(load_torque, overload_level);
    end

    // Slot assignment table; the host-side registers cannot reach it
    always_comb
    begin
        map_nxt = map_r;
        if (cfg_wr)
        begin
            map_nxt[cfg_slot] = cfg_src;
        end
    end

    // Status follows the sources every cycle, whatever the bus does
    always_comb
    begin
        for (int i = 0; i < SLOT_COUNT; i++)
        begin
            status_nxt[i] = src_value(map_r[i], three_wire, cmd, cond);
        end
    end

    // Register read and write answers, one cycle after the request
    always_comb
    begin
        rd_valid_nxt = rd_en;
        rd_err_nxt   = rd_en && !is_mapped(rd_addr);
        rd_data_nxt  = rd_data_r;
        if (rd_en)
        begin
            if (rd_addr == OFS_STATUS_LOWER)
            begin
                rd_data_nxt = status_r;
            end
            else
            begin
                rd_data_nxt = UPPER_READ_VALUE;
            end
        end
        // Writes are answered so the link layer can close the frame, then dropped
        wr_ack_nxt = wr_en && is_mapped(wr_addr);
        wr_err_nxt = wr_en && !is_mapped(wr_addr);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            map_r      <= DEFAULT_MAP;
            status_r   <= STATUS_RESET;
            rd_valid_r <= 1'b0;
            rd_err_r   <= 1'b0;
            rd_data_r  <= STATUS_RESET;
            wr_ack_r   <= 1'b0;
            wr_err_r   <= 1'b0;
        end
        else
        begin
            map_r      <= map_nxt;
            status_r   <= status_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_err_r   <= rd_err_nxt;
            rd_data_r  <= rd_data_nxt;
            wr_ack_r   <= wr_ack_nxt;
            wr_err_r   <= wr_err_nxt;
        end
    end

    assign rd_valid    = rd_valid_r;
    assign rd_err      = rd_err_r;
    assign rd_data     = rd_data_r;
    assign wr_ack      = wr_ack_r;
    assign wr_err      = wr_err_r;
    assign status_word = status_r;

    lower_read_a: assert property (
        @(posedge mclk) disable iff (rst)
        rd_en && rd_addr == OFS_STATUS_LOWER |=> rd_valid && rd_data == $past(status_r))
        else $error("lower status read returned wrong word");

    upper_zero_a: assert property (
        @(posedge mclk) disable iff (rst)
        rd_en && rd_addr == OFS_STATUS_UPPER |=> rd_valid && !rd_err && rd_data == 16'h0000)
        else $error("upper status read was not zero");

    reset_map_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> map_r[7] == SRC_FAULT && map_r[6] == SRC_WARNING
                    && map_r[3] == SRC_FWD_ECHO && map_r[0] == SRC_DATA_SEL0)
        else $error("lower byte default map wrong after reset");

    reset_upper_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> map_r[8] == SRC_BUSY && map_r[9] == SRC_UNUSED
                    && map_r[12] == SRC_OVERLOAD && map_r[15] == SRC_TORQUE_LIMIT)
        else $error("upper byte default map wrong after reset");

    three_wire_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[3] == SRC_FWD_ECHO && three_wire && !cfg_wr
        |=> status_r[3] == $past(cmd.run_gate))
        else $error("three-wire forward slot not showing run gate");

    cfg_bind_a: assert property (
        @(posedge mclk) disable iff (rst)
        cfg_wr ##1 !cfg_wr |=> status_r[$past(cfg_slot, 2)]
                               == src_value($past(cfg_src, 2), $past(three_wire),
                                            $past(cmd), $past(cond)))
        else $error("configured slot not following its new source");

    echo_sel_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[1] == SRC_DATA_SEL1 && !cfg_wr |=> status_r[1] == $past(cmd.data_sel[1]))
        else $error("data select echo mismatch");

    fault_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[7] == SRC_FAULT && !cfg_wr |=> status_r[7] == $past(pins_sync.fault))
        else $error("fault slot mismatch");

    warn_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[6] == SRC_WARNING && !cfg_wr |=> status_r[6] == $past(pins_sync.warning))
        else $error("warning slot mismatch");

    motion_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[13] == SRC_MOTION && !cfg_wr |=> status_r[13] == $past(pins_sync.motion))
        else $error("motion slot mismatch");

    torque_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[15] == SRC_TORQUE_LIMIT && !cfg_wr
        |=> status_r[15] == ($past(load_torque) > $past(torque_limit_val)))
        else $error("torque limit slot mismatch");

    speed_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[14] == SRC_SPEED_BAND && !cfg_wr && set_speed == actual_speed
        |=> !status_r[14])
        else $error("speed band flagged with equal speeds");

    overload_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[12] == SRC_OVERLOAD && !cfg_wr
        |=> status_r[12] == ($past(load_torque) > $past(overload_level)))
        else $error("overload slot mismatch");

    busy_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[8] == SRC_BUSY && !cfg_wr |=> status_r[8] == $past(pins_sync.internal_busy))
        else $error("busy slot mismatch");

    main_power_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[11] == SRC_MAIN_POWER && !cfg_wr
        |=> status_r[11] == $past(pins_sync.main_power))
        else $error("main power slot mismatch");

    shaft_dir_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[12] == SRC_SHAFT_DIR && !cfg_wr
        |=> status_r[12] == $past(pins_sync.shaft_fwd))
        else $error("shaft direction slot mismatch");

    unused_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        map_r[10] == SRC_UNUSED && !cfg_wr |=> !status_r[10])
        else $error("unused slot not zero");

    write_inert_a: assert property (
        @(posedge mclk) disable iff (rst)
        wr_en && !cfg_wr |=> wr_ack == is_mapped($past(wr_addr))
                             && map_r == $past(map_r))
        else $error("write disturbed the slot map");

endmodule

/* common/remote_out_pkg.sv */
// Shared constants and types for the remote output status map.
// Assumes one clock domain (mclk) with an active-high asynchronous reset.
package remote_out_pkg;

    localparam int SYNC_STAGES = 3;
    localparam int SLOT_COUNT  = 16;
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 16;

    localparam logic [ADDR_W-1:0] OFS_STATUS_UPPER = 16'h007e;
    localparam logic [ADDR_W-1:0] OFS_STATUS_LOWER = 16'h007f;
    localparam logic [DATA_W-1:0] STATUS_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] UPPER_READ_VALUE = 16'h0000;

    // Selectable source codes for one output slot
    typedef enum logic [4:0] {
        SRC_UNUSED        = 5'h00,
        SRC_FWD_ECHO      = 5'h01,
        SRC_REV_ECHO      = 5'h02,
        SRC_STOP_SEL_ECHO = 5'h03,
        SRC_RUN_GATE_ECHO = 5'h04,
        SRC_BRAKE_ECHO    = 5'h05,
        SRC_DIR_SEL_ECHO  = 5'h06,
        SRC_BRAKE_REL     = 5'h07,
        SRC_SHAFT_FREE    = 5'h08,
        SRC_DATA_SEL0     = 5'h09,
        SRC_DATA_SEL1     = 5'h0a,
        SRC_DATA_SEL2     = 5'h0b,
        SRC_FAULT         = 5'h0c,
        SRC_WARNING       = 5'h0d,
        SRC_MOTION        = 5'h0e,
        SRC_TORQUE_LIMIT  = 5'h0f,
        SRC_SPEED_BAND    = 5'h10,
        SRC_BUSY          = 5'h11,
        SRC_OVERLOAD      = 5'h12,
        SRC_MAIN_POWER    = 5'h13,
        SRC_SHAFT_DIR     = 5'h14
    } src_e;

    typedef src_e [SLOT_COUNT-1:0] map_t;

    localparam map_t DEFAULT_MAP = '{
        0:  SRC_DATA_SEL0,
        1:  SRC_DATA_SEL1,
        2:  SRC_DATA_SEL2,
        3:  SRC_FWD_ECHO,
        4:  SRC_REV_ECHO,
        5:  SRC_STOP_SEL_ECHO,
        6:  SRC_WARNING,
        7:  SRC_FAULT,
        8:  SRC_BUSY,
        9:  SRC_UNUSED,
        10: SRC_UNUSED,
        11: SRC_UNUSED,
        12: SRC_OVERLOAD,
        13: SRC_MOTION,
        14: SRC_SPEED_BAND,
        15: SRC_TORQUE_LIMIT
    };

    // Command inputs as held by the input command logic
    typedef struct packed {
        logic       fwd;
        logic       rev;
        logic       stop_sel;
        logic       run_gate;
        logic       brake_gate;
        logic       dir_sel;
        logic       brake_release;
        logic       shaft_free;
        logic [2:0] data_sel;
    } cmd_s;

    // Driver conditions arriving on pins from outside this clock domain
    typedef struct packed {
        logic fault;
        logic warning;
        logic motion;
        logic internal_busy;
        logic main_power;
        logic shaft_fwd;
    } pin_cond_s;

    localparam int PIN_COND_W = $bits(pin_cond_s);

    // Complete condition set after synchronising and comparing
    typedef struct packed {
        pin_cond_s pins;
        logic      torque_limit;
        logic      speed_band;
        logic      overload;
    } cond_s;

endpackage

/* rtl/slot_sync.sv */
// Three-stage synchroniser with agreement filter for a vector of pin levels.
// Assumes each bit is an independent level; bits may settle on different cycles.
`timescale 1ns/1ps
module slot_sync
    import remote_out_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // A change is taken only where the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

/* verif/modbus_poller.sv */
// Polling host model: issues single-pulse register reads and writes.
// Assumes the answer pulse arrives within a few mclk cycles of the request.
`timescale 1ns/1ps
module modbus_poller
    import remote_out_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rd_valid,
    input  wire logic              rd_err,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              wr_ack,
    input  wire logic              wr_err,
    output logic                   rd_en,
    output logic      [ADDR_W-1:0] rd_addr,
    output logic                   wr_en,
    output logic      [ADDR_W-1:0] wr_addr
);
    initial
    begin
        rd_en = 1'b0;
        rd_addr = '0;
        wr_en = 1'b0;
        wr_addr = '0;
    end

    // Read data comes back in d; a write returns its acknowledge in d[0]
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d, output logic e, output logic ok);
        ok = 1'b0;
        d = '0;
        e = 1'b0;
        @(posedge mclk);
        #1;
        if (wr)
        begin
            wr_en = 1'b1;
            wr_addr = a;
        end
        else
        begin
            rd_en = 1'b1;
            rd_addr = a;
        end
        @(posedge mclk);
        #1;
        // Released address lines show a changed value, never the old one
        rd_en = 1'b0;
        wr_en = 1'b0;
        rd_addr = ~a;
        wr_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            if (!wr && rd_valid === 1'b1)
            begin
                d = rd_data;
                e = rd_err;
                ok = 1'b1;
            end
            else if (wr && (wr_ack === 1'b1 || wr_err === 1'b1))
            begin
                d = {15'h0000, wr_ack};
                e = wr_err;
                ok = 1'b1;
            end
            else
            begin
                @(posedge mclk);
                #1;
            end
        end
    endtask
endmodule

/* verif/remote_output_status_map_tb_top.sv */
// Self-checking bench for the remote output status map.
// Assumes the poller model drives the register port; bench drives the sources.
`timescale 1ns/1ps
module remote_output_status_map_tb_top
    import remote_out_pkg::*;
;
    logic              mclk, rst, rd_en, rd_valid, rd_err, wr_en, wr_ack, wr_err;
    logic              cfg_wr, three_wire;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [DATA_W-1:0] rd_data, status_word;
    logic [3:0]        cfg_slot;
    src_e              cfg_src;
    cmd_s              cmd;
    pin_cond_s         cond_pins;
    logic [15:0]       set_speed, actual_speed, speed_band;
    logic [15:0]       load_torque, torque_limit_val, overload_level;
    int                bad_count, total_checks;
    src_e              exp_map [16];

    remote_output_status_map uut (.mclk(mclk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_ack(wr_ack), .wr_err(wr_err), .cfg_wr(cfg_wr),
        .cfg_slot(cfg_slot), .cfg_src(cfg_src), .three_wire(three_wire), .cmd(cmd),
        .cond_pins(cond_pins), .set_speed(set_speed), .actual_speed(actual_speed),
        .speed_band(speed_band), .load_torque(load_torque),
        .torque_limit_val(torque_limit_val), .overload_level(overload_level),
        .status_word(status_word));

    modbus_poller host (.mclk(mclk), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
        .wr_ack(wr_ack), .wr_err(wr_err), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
        .wr_addr(wr_addr));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic src_val(src_e c);
        logic [15:0] diff;
        diff = (set_speed > actual_speed) ? set_speed - actual_speed : actual_speed - set_speed;
        case (c)
            SRC_FWD_ECHO:      return three_wire ? cmd.run_gate : cmd.fwd;
            SRC_REV_ECHO:      return three_wire ? cmd.brake_gate : cmd.rev;
            SRC_STOP_SEL_ECHO: return three_wire ? cmd.dir_sel : cmd.stop_sel;
            SRC_RUN_GATE_ECHO: return cmd.run_gate;
            SRC_BRAKE_ECHO:    return cmd.brake_gate;
            SRC_DIR_SEL_ECHO:  return cmd.dir_sel;
            SRC_BRAKE_REL:     return cmd.brake_release;
            SRC_SHAFT_FREE:    return cmd.shaft_free;
            SRC_DATA_SEL0:     return cmd.data_sel[0];
            SRC_DATA_SEL1:     return cmd.data_sel[1];
            SRC_DATA_SEL2:     return cmd.data_sel[2];
            SRC_FAULT:         return cond_pins.fault;
            SRC_WARNING:       return cond_pins.warning;
            SRC_MOTION:        return cond_pins.motion;
            SRC_TORQUE_LIMIT:  return load_torque > torque_limit_val;
            SRC_SPEED_BAND:    return diff > speed_band;
            SRC_BUSY:          return cond_pins.internal_busy;
            SRC_OVERLOAD:      return load_torque > overload_level;
            SRC_MAIN_POWER:    return cond_pins.main_power;
            SRC_SHAFT_DIR:     return cond_pins.shaft_fwd;
            default:           return 1'b0;
        endcase
    endfunction

    task automatic set_default();
        exp_map = '{SRC_DATA_SEL0, SRC_DATA_SEL1, SRC_DATA_SEL2, SRC_FWD_ECHO, SRC_REV_ECHO,
                    SRC_STOP_SEL_ECHO, SRC_WARNING, SRC_FAULT, SRC_BUSY, SRC_UNUSED,
                    SRC_UNUSED, SRC_UNUSED, SRC_OVERLOAD, SRC_MOTION, SRC_SPEED_BAND,
                    SRC_TORQUE_LIMIT};
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [15:0] a, output logic [15:0] d,
                       output logic e);
        logic ok;
        host.xfer(wr, a, d, e, ok);
        if (!ok)
        begin
            bad_count++;
            conclude();
        end
    endtask

    task automatic drive(input cmd_s c, input pin_cond_s p, input logic [15:0] s, a, b,
                         input logic [15:0] l, tl, ov);
        @(posedge mclk);
        #1;
        cmd = c;
        cond_pins = p;
        set_speed = s;
        actual_speed = a;
        speed_band = b;
        load_torque = l;
        torque_limit_val = tl;
        overload_level = ov;
    endtask

    // Pin conditions need about five cycles through the synchroniser
    task automatic check_lower();
        logic [15:0] d, x;
        logic        e;
        repeat (8) @(posedge mclk);
        #1;
        for (int i = 0; i < 16; i++)
            x[i] = src_val(exp_map[i]);
        check("status_word", status_word, x);
        bus(1'b0, OFS_STATUS_LOWER, d, e);
        check("lower", d, x);
        check("lower err", {15'h0000, e}, 16'h0000);
    endtask

    task automatic t_reset();
        logic [15:0] d;
        logic        e;
        bus(1'b0, OFS_STATUS_UPPER, d, e);
        check("upper", d, 16'h0000);
        check_lower();
    endtask

    task automatic t_default();
        drive(11'h505, 6'h24, 16'h0000, 16'h0000, 16'h0000, 16'h000b, 16'h000a, 16'h0032);
        check_lower();
        drive(11'h212, 6'h18, 16'h0064, 16'h005f, 16'h0004, 16'h0015, 16'h001e, 16'h0014);
        check_lower();
        // Equal to the band or the limit must still read as within it
        drive(11'h000, 6'h00, 16'h0064, 16'h0068, 16'h0004, 16'h001e, 16'h001e, 16'h001e);
        check_lower();
    endtask

    task automatic t_three_wire();
        @(posedge mclk);
        #1;
        three_wire = 1'b1;
        // Each echo pair set to opposite levels so a missed swap shows in every slot
        drive(11'h2a0, 6'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        check_lower();
        drive(11'h540, 6'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        check_lower();
        @(posedge mclk);
        #1;
        three_wire = 1'b0;
    endtask

    task automatic t_config();
        for (int r = 0; r < 3; r++)
        begin
            @(posedge mclk);
            #1;
            cfg_wr = 1'b1;
            for (int i = 0; i < 16; i++)
            begin
                cfg_slot = i[3:0];
                cfg_src = src_e'(5'((i + r * 8) % 21));
                exp_map[i] = cfg_src;
                @(posedge mclk);
                #1;
            end
            cfg_wr = 1'b0;
            three_wire = (r == 1);
            if (r % 2 == 0)
                drive(11'h555, 6'h2a, 16'h000a, 16'h0000, 16'h0003, 16'h0028, 16'h001e,
                      16'h0032);
            else
                drive(11'h2aa, 6'h17, 16'h000a, 16'h000a, 16'h0003, 16'h003c, 16'h0046,
                      16'h0032);
            check_lower();
        end
        three_wire = 1'b0;
        // A reset in mid-run must bring the default map back
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        set_default();
        check_lower();
    endtask

    task automatic t_writes();
        logic [15:0] d;
        logic        e;
        bus(1'b1, OFS_STATUS_UPPER, d, e);
        check("wr upper ack", {d[0], e}, 16'h0002);
        bus(1'b1, OFS_STATUS_LOWER, d, e);
        check("wr lower ack", {d[0], e}, 16'h0002);
        bus(1'b1, 16'h0081, d, e);
        check("wr unmapped", {d[0], e}, 16'h0001);
        check_lower();
        bus(1'b0, 16'h0080, d, e);
        check("rd unmapped", d, 16'h0000);
        check("rd unmapped err", {15'h0000, e}, 16'h0001);
        bus(1'b0, OFS_STATUS_UPPER, d, e);
        check("upper after writes", d, 16'h0000);
    endtask

    initial
    begin
        bad_count = 0;
        total_checks = 0;
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_slot = 4'h0;
        cfg_src = SRC_UNUSED;
        three_wire = 1'b0;
        cmd = '0;
        cond_pins = '0;
        set_speed = 16'h0000;
        actual_speed = 16'h0000;
        speed_band = 16'h0000;
        load_torque = 16'h0000;
        torque_limit_val = 16'h0000;
        overload_level = 16'h0000;
        set_default();
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_reset();
        t_default();
        t_three_wire();
        t_config();
        t_writes();
        conclude();
    end
endmodule
